// >>> rtl/power_mode_pkg.sv
/*
 * Shared constants and types of the power mode controller.
 * Assumes an 8-bit special-register port driven by the processor core.
 */
`default_nettype none

package power_mode_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] POWER_CONTROL_ADDR  = 8'h87;
   localparam logic [7:0] CLOCK_CONTROL_ADDR  = 8'hf9;
   localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
   localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h50;

   localparam int BIT_HALT_CORE  = 0;
   localparam int BIT_DEEP_SLEEP = 1;
   localparam int BIT_UART1_TX   = 2;
   localparam int BIT_UART1_RX   = 3;
   localparam int BIT_COLD_START = 4;
   localparam int BIT_RESERVED   = 5;
   localparam int BIT_UART1_DBL  = 6;
   localparam int BIT_UART0_DBL  = 7;
   localparam int BIT_AUTO_SPEED = 3;
   localparam int PRESCALE_LSB   = 0;
   localparam int PRESCALE_W     = 3;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int RESTART_MACHINE_CYCLES = 3;
   localparam int CORE_TICKS_PER_MACHINE = 4;
   localparam int PRESCALE_MAX_SHIFT     = 11;
   localparam logic [7:0] BUS_PARK_BYTE  = 8'hff;
   localparam int PORT_BITS              = 24;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_RUN,
      MODE_IDLE,
      MODE_DEEP,
      MODE_RESTART
   } mode_t;

   typedef struct packed {
      logic external_irq_a;
      logic external_irq_b;
      logic timers;
      logic uarts;
      logic spi;
      logic counter_array;
      logic usb;
   } irq_src_t;

   typedef struct packed {
      logic power_on;
      logic ext_pin;
      logic low_voltage;
      logic debug_cmd;
      logic watchdog;
   } sup_reset_t;

   typedef struct packed {
      logic       ale;
      logic       program_strobe_n;
      logic       read_strobe_n;
      logic       write_strobe_n;
      logic [7:0] muxed_address_data;
      logic [7:0] high_address;
   } ext_bus_t;

   // Divisor as a power of two: 1,2,4,8,16,32,1024,2048
   function automatic logic [3:0] prescale_shift(input logic [2:0] code);
      case (code)
         3'h0:    prescale_shift = 4'h0;
         3'h1:    prescale_shift = 4'h1;
         3'h2:    prescale_shift = 4'h2;
         3'h3:    prescale_shift = 4'h3;
         3'h4:    prescale_shift = 4'h4;
         3'h5:    prescale_shift = 4'h5;
         3'h6:    prescale_shift = 4'ha;
         default: prescale_shift = 4'hb;
      endcase
   endfunction

endpackage

`default_nettype wire

// >>> rtl/core_clock_prescaler.sv
/*
 * Divides the oscillator clock into a core tick pulse.
 * Assumes the select code is stable or changes only between ticks.
 */
`default_nettype none

module core_clock_prescaler #(
   parameter int CNT_W = power_mode_pkg::PRESCALE_MAX_SHIFT
) (
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   input  wire logic       stop,
   input  wire logic [2:0] code,
   output logic            tick
);
   import power_mode_pkg::*;

   generate
      if (CNT_W < PRESCALE_MAX_SHIFT)
      begin : g_chk
         $error("prescaler counter too narrow");
      end
   endgenerate

   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] limit;
   logic [2:0]       code_reg;

   assign limit = CNT_W'((1 << prescale_shift(code)) - 1);
   assign tick  = !stop && (count_reg == limit);

   // Restart the count on a new code so the first period is whole
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst || stop || (code != code_reg))
         count_reg <= '0;
      else if (count_reg == limit)
         count_reg <= '0;
      else
         count_reg <= count_reg + CNT_W'(1);
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         code_reg <= 3'h0;
      else
         code_reg <= code;
   end

endmodule

`default_nettype wire

// >>> rtl/restart_delay.sv
/*
 * Counts a fixed number of core ticks after a supervisor reset.
 * Assumes the tick input is a one-cycle pulse.
 */
`default_nettype none

module restart_delay #(
   parameter int COUNT = power_mode_pkg::RESTART_MACHINE_CYCLES
                       * power_mode_pkg::CORE_TICKS_PER_MACHINE
) (
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   input  wire logic load,
   input  wire logic tick,
   output logic      done
);
   import power_mode_pkg::*;

   generate
      if (COUNT < 1 || COUNT > 255)
      begin : g_chk
         $error("restart count out of range");
      end
   endgenerate

   logic [7:0] left_reg;

   // Ends on the last tick itself, so the hold spans exactly COUNT ticks
   assign done = ((left_reg == 8'h00) || (left_reg == 8'h01 && tick)) && !load;

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         left_reg <= 8'h00;
      else if (load)
         left_reg <= 8'(COUNT);
      else if (tick && left_reg != 8'h00)
         left_reg <= left_reg - 8'h01;
   end

endmodule

`default_nettype wire

// >>> rtl/power_mode_control.sv
/*
 * Power mode control of the microcontroller: idle, deep sleep,
 * core clock prescaling and the power control register.
 * Assumes the core writes registers over the special-register port,
 * that irq_req carries enabled, pending interrupts and that
 * sup_reset carries one-cycle reset events from the supervisor.
 */
// Behaviour
// - Idle stops only the core clock (code also gates the watchdog clock)
// - Interrupt or supervisor reset ends idle
// - Idle starts right after setting write
// - Core state frozen while idle
// - Interrupt clears idle bit, core resumes
// - Supervisor reset: clear idle, restart later
// - Watchdog inactive in idle, others reset
// - Port outputs held in both modes
// - Deep sleep stops oscillator and clocks
// - Deep sleep right after write, state kept
// - Only supervisor resets end deep sleep
// - Bus parked: strobes high, lines ones
// - Three-bit prescaler divides core clock
// - Prescaled clock feeds only core, watchdog
// - Auto restore forces prescaler to zero
// - Cold flag set only by power-on
// - Bit 1 requests deep sleep
// - Baud, reserved and UART1 flag bits
// - Codes select 1 to 2048 divisors
// - Auto restore enable at bit 3
`default_nettype none

module power_mode_control (
   input  wire logic                             clk_sys,
   input  wire logic                             sys_rst,
   input  wire logic [7:0]                       sfr_addr,
   input  wire logic                             sfr_wr_en,
   input  wire logic [7:0]                       sfr_wdata,
   output logic [7:0]                            sfr_rd_data,
   input  wire power_mode_pkg::irq_src_t         irq_req,
   input  wire power_mode_pkg::sup_reset_t       sup_reset,
   input  wire power_mode_pkg::ext_bus_t         core_bus,
   input  wire logic [power_mode_pkg::PORT_BITS-1:0] core_port,
   output logic                                  core_clk_en,
   output logic                                  watchdog_clk_en,
   output logic                                  peripheral_clock_run,
   output logic                                  usb_clock_run,
   output logic                                  osc_run,
   output logic                                  core_restart_hold,
   output logic                                  uart0_baud_double,
   output logic                                  uart1_baud_double,
   output logic                                  uart1_receive_clock_flag,
   output logic                                  uart1_transmit_clock_flag,
   output power_mode_pkg::mode_t                 mode,
   output power_mode_pkg::ext_bus_t              ext_bus,
   output logic [power_mode_pkg::PORT_BITS-1:0]  port_out
);
   import power_mode_pkg::*;

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [7:0]     power_control_reg;
   logic [7:0]     power_control_next;
   logic [7:0]     clock_control_reg;
   logic [7:0]     clock_control_next;
   mode_t          mode_reg;
   mode_t          mode_next;
   ext_bus_t       ext_bus_reg;
   ext_bus_t       parked_bus;
   logic [PORT_BITS-1:0] port_reg;
   logic [7:0]     rd_data_reg;
   logic           wr_power;
   logic           wr_clock;
   logic           irq_any;
   logic           sup_any;
   logic           tick;
   logic           restart_done;
   logic           sleeping;
   logic           deep;

   assign wr_power = sfr_wr_en && (sfr_addr == POWER_CONTROL_ADDR)
                     && (mode_reg == MODE_RUN);
   assign wr_clock = sfr_wr_en && (sfr_addr == CLOCK_CONTROL_ADDR)
                     && (mode_reg == MODE_RUN);
   assign irq_any  = |irq_req;
   assign deep     = (mode_reg == MODE_DEEP);
   assign sleeping = (mode_reg == MODE_IDLE) || deep;

   // ---------------------------------------------------------------
   // Supervisor reset qualification
   // ---------------------------------------------------------------
   // Watchdog masked while idle
   assign sup_any = sup_reset.power_on || sup_reset.ext_pin
                    || sup_reset.low_voltage || sup_reset.debug_cmd
                    || (sup_reset.watchdog && !sleeping);

   // ---------------------------------------------------------------
   // Prescaler and restart delay
   // ---------------------------------------------------------------
   // Oscillator stopped, no ticks
   core_clock_prescaler #(
      .CNT_W   (PRESCALE_MAX_SHIFT)
   ) u_prescaler (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .stop    (deep),
      .code    (clock_control_reg[PRESCALE_LSB +: PRESCALE_W]),
      .tick    (tick)
   );

   restart_delay #(
      .COUNT   (RESTART_MACHINE_CYCLES * CORE_TICKS_PER_MACHINE)
   ) u_restart (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .load    (sup_any),
      .tick    (tick),
      .done    (restart_done)
   );

   // ---------------------------------------------------------------
   // Mode sequencing
   // ---------------------------------------------------------------
   always_comb
   begin
      mode_next = mode_reg;
      case (mode_reg)
         MODE_RUN:
         begin
            if (wr_power && sfr_wdata[BIT_DEEP_SLEEP])
               mode_next = MODE_DEEP;
            else if (wr_power && sfr_wdata[BIT_HALT_CORE])
               mode_next = MODE_IDLE;
         end
         MODE_IDLE:
         begin
            if (irq_any)
               mode_next = MODE_RUN;
         end
         MODE_DEEP:
         begin
            mode_next = MODE_DEEP;
         end
         MODE_RESTART:
         begin
            if (restart_done)
               mode_next = MODE_RUN;
         end
         default:
         begin
            mode_next = MODE_RUN;
         end
      endcase
      if (sup_any)
         mode_next = MODE_RESTART;
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         mode_reg <= MODE_RUN;
      else
         mode_reg <= mode_next;
   end

   // ---------------------------------------------------------------
   // Power control register
   // ---------------------------------------------------------------
   always_comb
   begin
      power_control_next = power_control_reg;
      if (wr_power)
      begin
         power_control_next = sfr_wdata;
         // Reserved bit stays zero
         power_control_next[BIT_RESERVED] = 1'b0;
         power_control_next[BIT_COLD_START] =
            power_control_reg[BIT_COLD_START] && sfr_wdata[BIT_COLD_START];
      end
      if (mode_reg == MODE_IDLE && irq_any)
         power_control_next[BIT_HALT_CORE] = 1'b0;
      if (sup_any)
      begin
         // Warm reset keeps the cold flag
         power_control_next = POWER_CONTROL_RESET;
         power_control_next[BIT_COLD_START] =
            power_control_reg[BIT_COLD_START];
         if (sup_reset.power_on)
            power_control_next[BIT_COLD_START] = 1'b1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         power_control_reg <= POWER_CONTROL_RESET;
      else
         power_control_reg <= power_control_next;
   end

   // ---------------------------------------------------------------
   // Clock control register
   // ---------------------------------------------------------------
   always_comb
   begin
      clock_control_next = clock_control_reg;
      if (wr_clock)
         clock_control_next = sfr_wdata;
      // Hardware restore wins over a same-cycle firmware write
      // Interrupt restores full speed
      if (clock_control_reg[BIT_AUTO_SPEED] && irq_any && !deep)
         clock_control_next[PRESCALE_LSB +: PRESCALE_W] = 3'h0;
      if (sup_any)
         clock_control_next = CLOCK_CONTROL_RESET;
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         clock_control_reg <= CLOCK_CONTROL_RESET;
      else
         clock_control_reg <= clock_control_next;
   end

   // ---------------------------------------------------------------
   // Register read port
   // ---------------------------------------------------------------
   // Read data is one cycle behind the address
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         rd_data_reg <= 8'h00;
      else if (sfr_addr == POWER_CONTROL_ADDR)
         rd_data_reg <= power_control_reg;
      else if (sfr_addr == CLOCK_CONTROL_ADDR)
         rd_data_reg <= clock_control_reg;
      else
         rd_data_reg <= 8'h00;
   end

   assign sfr_rd_data = rd_data_reg;

   // ---------------------------------------------------------------
   // Clock gating
   // ---------------------------------------------------------------
   // Core halted, peripherals run
   assign core_clk_en = tick && (mode_reg == MODE_RUN);

   assign watchdog_clk_en = tick && !sleeping;

   assign peripheral_clock_run = !deep;
   assign usb_clock_run        = !deep;
   assign osc_run              = !deep;

   // Core held until the delay ends
   assign core_restart_hold = (mode_reg == MODE_RESTART);

   assign uart0_baud_double         = power_control_reg[BIT_UART0_DBL];
   assign uart1_baud_double         = power_control_reg[BIT_UART1_DBL];
   assign uart1_receive_clock_flag  = power_control_reg[BIT_UART1_RX];
   assign uart1_transmit_clock_flag = power_control_reg[BIT_UART1_TX];
   assign mode                      = mode_reg;

   // ---------------------------------------------------------------
   // External bus parking
   // ---------------------------------------------------------------
   always_comb
   begin
      parked_bus                    = core_bus;
      parked_bus.ale                = 1'b0;
      parked_bus.program_strobe_n   = 1'b1;
      parked_bus.read_strobe_n      = 1'b1;
      parked_bus.write_strobe_n     = 1'b1;
      parked_bus.muxed_address_data = BUS_PARK_BYTE;
      parked_bus.high_address       = BUS_PARK_BYTE;
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         ext_bus_reg <= parked_bus;
      else if (sleeping || mode_next == MODE_IDLE
               || mode_next == MODE_DEEP)
         ext_bus_reg <= parked_bus;
      else
         ext_bus_reg <= core_bus;
   end

   assign ext_bus = ext_bus_reg;

   // ---------------------------------------------------------------
   // Port hold
   // ---------------------------------------------------------------
   // Ports default to all ones, the input-ready level
   // Levels frozen while sleeping
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         port_reg <= '1;
      else if (!sleeping)
         port_reg <= core_port;
   end

   assign port_out = port_reg;

endmodule

`default_nettype wire

// >>> dv/core_model.sv
/*
 * Behavioural processor core side: bus drive and port levels.
 * Assumes the controller alone decides what reaches the pins.
 */
`default_nettype none

module core_model (
   input  wire logic                                 clk_sys,
   output var power_mode_pkg::ext_bus_t              core_bus,
   output var logic [power_mode_pkg::PORT_BITS-1:0]  core_port
);
   timeunit 1ns;
   timeprecision 1ps;
   import power_mode_pkg::*;

   // Changes every cycle, so a pin that fails to hold shows at once
   logic [19:0] cnt_reg = 20'h0_0000;

   always @(posedge clk_sys)
      cnt_reg <= #1 cnt_reg + 20'h0_1357;

   assign core_bus  = ext_bus_t'(cnt_reg);
   assign core_port = {cnt_reg[3:0], cnt_reg};
endmodule

`default_nettype wire

// >>> dv/power_mode_sva.sv
/*
 * Port checker of the power mode controller.
 * Assumes it is bound to the controller top and sees only its ports.
 */
`default_nettype none

module power_mode_sva (
   input wire logic                        clk_sys,
   input wire logic                        sys_rst,
   input wire logic [7:0]                  sfr_addr,
   input wire logic                        sfr_wr_en,
   input wire logic [7:0]                  sfr_wdata,
   input wire power_mode_pkg::irq_src_t    irq_req,
   input wire power_mode_pkg::sup_reset_t  sup_reset,
   input wire logic                        core_clk_en,
   input wire logic                        watchdog_clk_en,
   input wire logic                        peripheral_clock_run,
   input wire logic                        usb_clock_run,
   input wire logic                        osc_run,
   input wire logic                        core_restart_hold,
   input wire power_mode_pkg::mode_t       mode,
   input wire power_mode_pkg::ext_bus_t    ext_bus,
   input wire logic [23:0]                 port_out
);
   import power_mode_pkg::*;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   logic low_pwr;
   logic hard_rst;
   assign low_pwr  = (mode == MODE_IDLE) || (mode == MODE_DEEP);
   // Watchdog left out: it never ends a sleep mode
   assign hard_rst = sup_reset.power_on | sup_reset.ext_pin | sup_reset.low_voltage
                   | sup_reset.debug_cmd;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   sequence sleep_wr(int b);
      sfr_wr_en && (sfr_addr == POWER_CONTROL_ADDR) && sfr_wdata[b]
      && (mode == MODE_RUN) && (sup_reset == '0);
   endsequence
   sequence asleep_twice;
      low_pwr ##1 low_pwr;
   endsequence
   sequence restart_run;
      core_restart_hold [*8] ##[3:6] (mode == MODE_RUN);
   endsequence

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   idle_entry_a: assert property (
      sleep_wr(0) ##0 !sfr_wdata[1] |=> mode == MODE_IDLE) else $error("idle not entered");
   deep_entry_a: assert property (
      sleep_wr(1) |=> mode == MODE_DEEP) else $error("deep sleep not entered");
   bus_park_a: assert property (
      low_pwr |-> ext_bus == {4'h7, BUS_PARK_BYTE, BUS_PARK_BYTE}) else $error("bus not parked");
   idle_clocks_a: assert property (
      mode == MODE_IDLE |-> !core_clk_en && !watchdog_clk_en && peripheral_clock_run
      && usb_clock_run && osc_run) else $error("idle clock gating wrong");
   deep_clocks_a: assert property (
      mode == MODE_DEEP |-> !(core_clk_en || watchdog_clk_en || peripheral_clock_run
      || usb_clock_run || osc_run)) else $error("deep sleep clock still running");
   idle_wake_a: assert property (
      mode == MODE_IDLE && irq_req != '0 && !hard_rst |=> mode == MODE_RUN)
      else $error("interrupt did not end idle");
   idle_stay_a: assert property (
      mode == MODE_IDLE && irq_req == '0 && !hard_rst |=> mode == MODE_IDLE)
      else $error("idle left without cause");
   deep_stay_a: assert property (
      mode == MODE_DEEP && !hard_rst |=> mode == MODE_DEEP) else $error("deep sleep left");
   port_hold_a: assert property (
      asleep_twice |-> $stable(port_out)) else $error("port output moved while asleep");
   restart_go_a: assert property (
      hard_rst |=> core_restart_hold && mode == MODE_RESTART) else $error("no restart");
   restart_len_a: assert property (
      $rose(core_restart_hold) |-> restart_run) else $error("restart length wrong");
endmodule

bind power_mode_control power_mode_sva u_sva (.*);

`default_nettype wire

// >>> dv/tb_top.sv
/*
 * Self-checking bench of the power mode controller.
 * Assumes the core model drives the bus and port inputs.
 */
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import power_mode_pkg::*;

   // ---------------------------------------------------------------
   // Signals and instances
   // ---------------------------------------------------------------
   localparam logic [23:0] PARK = 24'h07_ffff;
   logic                 clk_sys = 1'b0;
   logic                 sys_rst;
   logic [7:0]           sfr_addr;
   logic                 sfr_wr_en;
   logic [7:0]           sfr_wdata;
   logic [7:0]           sfr_rd_data;
   irq_src_t             irq_req;
   sup_reset_t           sup_reset;
   ext_bus_t             core_bus;
   ext_bus_t             ext_bus;
   logic [PORT_BITS-1:0] core_port;
   logic [PORT_BITS-1:0] port_out;
   logic                 core_clk_en;
   logic                 watchdog_clk_en;
   logic                 peripheral_clock_run;
   logic                 usb_clock_run;
   logic                 osc_run;
   logic                 core_restart_hold;
   logic                 uart0_baud_double;
   logic                 uart1_baud_double;
   logic                 uart1_receive_clock_flag;
   logic                 uart1_transmit_clock_flag;
   mode_t                mode;
   int                   error_cnt = 0;
   int                   n_compared = 0;
   int                   cyc = 0;
   int                   div_tbl[8] = '{1, 2, 4, 8, 16, 32, 1024, 2048};

   always #10 clk_sys = ~clk_sys;
   core_model u_core (.clk_sys(clk_sys), .core_bus(core_bus), .core_port(core_port));
   power_mode_control DUT (.*);

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic wrap_up();
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
      n_compared++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic step();
      @(posedge clk_sys);
      #1;
   endtask
   // Extra cycle so a following write never raises the strobe in the same step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr  = a;
      sfr_wdata = d;
      sfr_wr_en = 1'b1;
      step();
      sfr_wr_en = 1'b0;
      step();
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      sfr_addr = a;
      step();
      chk(24'(sfr_rd_data), 24'(exp), "register read");
   endtask
   task automatic irq(input int i);
      irq_req = irq_src_t'(7'h01 << i);
      step();
      irq_req = '0;
   endtask
   task automatic sup(input logic [4:0] v);
      sup_reset = sup_reset_t'(v);
      step();
      sup_reset = '0;
   endtask
   task automatic restart(input logic [4:0] v);
      int n;
      n = 0;
      sup(v);
      chk(24'(core_restart_hold), 24'h00_0001, "restart hold");
      while (mode !== MODE_RUN && n < 300)
      begin
         step();
         n++;
      end
      chk(24'(n), 24'(RESTART_MACHINE_CYCLES * CORE_TICKS_PER_MACHINE), "restart length");
   endtask
   task automatic count_ticks(input int div);
      int nc;
      int nw;
      nc = 0;
      nw = 0;
      repeat (2100) step();
      repeat (4096)
      begin
         step();
         nc += int'(core_clk_en === 1'b1);
         nw += int'(watchdog_clk_en === 1'b1);
      end
      chk(24'(nc), 24'(4096 / div), "core ticks");
      chk(24'(nw), 24'(4096 / div), "watchdog ticks");
      chk(24'(peripheral_clock_run), 24'h00_0001, "peripheral clock");
   endtask

   // ---------------------------------------------------------------
   // Sequence and watchdog of the run
   // ---------------------------------------------------------------
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         error_cnt++;
         $display("ERROR %0t run timed out", $time);
         wrap_up();
      end
   end

   initial
   begin
      sys_rst   = 1'b1;
      sfr_addr  = 8'h00;
      sfr_wr_en = 1'b0;
      sfr_wdata = 8'h00;
      irq_req   = '0;
      sup_reset = '0;
      repeat (16) @(posedge clk_sys);
      #1;
      sys_rst = 1'b0;
      rd(POWER_CONTROL_ADDR, POWER_CONTROL_RESET);
      rd(CLOCK_CONTROL_ADDR, CLOCK_CONTROL_RESET);
      rd(8'h42, 8'h00);
      wr(POWER_CONTROL_ADDR, 8'hec);
      rd(POWER_CONTROL_ADDR, 8'hcc);
      chk(24'({uart0_baud_double, uart1_baud_double, uart1_receive_clock_flag,
               uart1_transmit_clock_flag}), 24'h00_000f, "uart bits");
      wr(POWER_CONTROL_ADDR, 8'h00);
      for (int c = 0; c < 8; c++)
      begin
         wr(CLOCK_CONTROL_ADDR, 8'h50 + 8'(c));
         count_ticks(div_tbl[c]);
      end
      wr(CLOCK_CONTROL_ADDR, 8'h5d);
      irq(2);
      rd(CLOCK_CONTROL_ADDR, 8'h58);
      wr(CLOCK_CONTROL_ADDR, 8'h55);
      irq(3);
      rd(CLOCK_CONTROL_ADDR, 8'h55);
      wr(CLOCK_CONTROL_ADDR, 8'h50);
      for (int i = 0; i < 7; i++)
      begin
         wr(POWER_CONTROL_ADDR, 8'h01);
         chk(24'(mode), 24'(MODE_IDLE), "idle entry");
         chk(24'(core_clk_en), 24'h00_0000, "core clock in idle");
         chk(24'(ext_bus), PARK, "bus park");
         irq(i);
         chk(24'(mode), 24'(MODE_RUN), "idle wake");
         rd(POWER_CONTROL_ADDR, 8'h00);
      end
      wr(POWER_CONTROL_ADDR, 8'h01);
      sup(5'h01);
      chk(24'(mode), 24'(MODE_IDLE), "watchdog in idle");
      // Gap so two reset pulses are never merged in one step
      step();
      restart(5'h04);
      rd(POWER_CONTROL_ADDR, 8'h00);
      for (int j = 0; j < 3; j++)
      begin
         wr(POWER_CONTROL_ADDR, (j == 0) ? 8'h03 : 8'h02);
         chk(24'(mode), 24'(MODE_DEEP), "deep entry");
         chk(24'({osc_run, peripheral_clock_run, usb_clock_run}), 24'h00_0000, "clocks");
         chk(24'(ext_bus), PARK, "bus park");
         irq(j);
         sup(5'h01);
         chk(24'(mode), 24'(MODE_DEEP), "deep kept");
         step();
         restart(5'h08 >> j);
         rd(POWER_CONTROL_ADDR, 8'h00);
      end
      restart(5'h10);
      rd(POWER_CONTROL_ADDR, 8'h10);
      wr(POWER_CONTROL_ADDR, 8'h10);
      rd(POWER_CONTROL_ADDR, 8'h10);
      wr(POWER_CONTROL_ADDR, 8'h00);
      rd(POWER_CONTROL_ADDR, 8'h00);
      restart(5'h08);
      rd(POWER_CONTROL_ADDR, 8'h00);
      // Watchdog still resets while running
      restart(5'h01);
      rd(POWER_CONTROL_ADDR, 8'h00);
      wrap_up();
   end
endmodule

`default_nettype wire
